/* core/rxg_pkg.sv */
// shared constants for the receive gain, filter and offset calibration control
package rxg_pkg;
  // ==========================================================================
  // register map (serial port addresses)
  localparam logic [6:0] ADDR_RX_PATH_CONFIG = 7'h07;
  localparam logic [6:0] ADDR_FILTER_CUTOFF_TARGET = 7'h08;
  localparam logic [6:0] ADDR_GAIN_CONTROL = 7'h09;
  localparam logic [6:0] ADDR_CAL_CONTROL = 7'h0a;
  localparam logic [6:0] ADDR_CAL_STATUS = 7'h0b;
  localparam logic [6:0] ADDR_CAL_DAC = 7'h0c;
  // ==========================================================================
  // field positions and reset values
  localparam int CFG_LPF_EN_BIT = 0;
  localparam int GAIN_ALT_BIT = 6;
  localparam int CALCTL_OCAL_REQ_BIT = 0;
  localparam logic [7:0] RST_RX_PATH_CONFIG = 8'h01;
  localparam logic [7:0] RST_FILTER_CUTOFF_TARGET = 8'h80;
  localparam logic [7:0] RST_GAIN_CONTROL = 8'h0c;
  // ==========================================================================
  // gain plan, in 1 db units above the -12 db floor
  localparam int GAIN_CODE_W = 6;
  localparam int ALT_CODE_W = 3;
  localparam logic [5:0] GAIN_MAX_IDX = 6'h3c;
  localparam logic [5:0] ALT_STEP_DB = 6'h08;
  localparam logic [5:0] ALT_MAX_IDX = 6'h30;
  localparam logic [5:0] COARSE_STEP_DB = 6'h06;
  localparam logic [3:0] COARSE_MAX_LVL = 4'h9;
  localparam logic [2:0] STAGE1_MAX_LVL = 3'h5;
  localparam logic [2:0] STAGE2_MAX_LVL = 3'h4;
  localparam logic [2:0] FINE_MAX_LVL = 3'h6;
  // ==========================================================================
  // offset servo
  localparam int ADC_W = 12;
  localparam logic signed [11:0] OFFSET_WINDOW_LSB = 12'sh020;
  localparam int CAL_DAC_W = 8;
  localparam logic [7:0] CAL_DAC_MID = 8'h80;
  localparam int OCAL_SETTLE_CYC = 64;
  localparam int OCAL_MAX_STEPS = 255;
  // ==========================================================================
  // filter calibration timing
  localparam int CLK_MHZ = 40;
  localparam int FCAL_LIMIT_US = 100;
  localparam int FCAL_LIMIT_CYC = FCAL_LIMIT_US * CLK_MHZ;
  localparam int FCAL_BITS = 8;
  localparam int FCAL_STEP_CYC = FCAL_LIMIT_CYC / (FCAL_BITS + 1);
  // ==========================================================================
  // serial frame: rw, 7-bit address, 8-bit data, msb first
  localparam int SER_FRAME_BITS = 16;
  localparam int SER_HDR_BITS = 8;
endpackage

/* core/rxg_gain_if.sv */
// gain request and per-stage settings between the control core and the lookup table
`timescale 1ns/1ps
`default_nettype none
interface rxg_gain_if;
  logic [5:0] gain_code;
  logic alt_mode;
  logic [2:0] stage1_lvl;
  logic [2:0] stage2_lvl;
  logic [2:0] fine_lvl;
  modport ctrl (output gain_code, output alt_mode, input stage1_lvl, input stage2_lvl, input fine_lvl);
  modport lut (input gain_code, input alt_mode, output stage1_lvl, output stage2_lvl, output fine_lvl);
endinterface
`default_nettype wire

/* core/rxg_gain_lut.sv */
// gain code to coarse and fine stage settings lookup
`timescale 1ns/1ps
`default_nettype none
module rxg_gain_lut (
  input wire logic clk,
  input wire logic rst_n,
  rxg_gain_if.lut gif
);
  import rxg_pkg::*;

  // ==========================================================================
  // map
  logic [5:0] idx;
  logic [3:0] coarse;
  logic [5:0] rem_db;
  logic [2:0] nxt_s1;
  logic [2:0] nxt_s2;

  always_comb begin
    if (gif.alt_mode) begin
      idx = 6'(gif.gain_code[ALT_CODE_W-1:0] * ALT_STEP_DB);
      if (idx > ALT_MAX_IDX) begin
        idx = ALT_MAX_IDX; // alternate range stops at +36 db, top code clamps
      end
    end else if (gif.gain_code > GAIN_MAX_IDX) begin
      idx = GAIN_MAX_IDX; // codes past +48 db clamp
    end else begin
      idx = gif.gain_code;
    end
    coarse = 4'(idx / COARSE_STEP_DB);
    if (coarse > COARSE_MAX_LVL) begin
      coarse = COARSE_MAX_LVL;
    end
    rem_db = 6'(idx - 6'(coarse * COARSE_STEP_DB));
    // first stage filled first: its preamp noise dominates at high gain
    nxt_s1 = (coarse > 4'(STAGE1_MAX_LVL)) ? STAGE1_MAX_LVL : coarse[2:0];
    nxt_s2 = 3'(coarse - 4'(nxt_s1));
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      gif.stage1_lvl <= 3'h0;
      gif.stage2_lvl <= 3'h0;
      gif.fine_lvl <= 3'h0;
    end else begin
      gif.stage1_lvl <= nxt_s1;
      gif.stage2_lvl <= nxt_s2;
      gif.fine_lvl <= rem_db[2:0];
    end
  end
endmodule // rxg_gain_lut
`default_nettype wire

/* core/rxg_ctrl.sv */
// receive gain, low-pass filter and offset calibration control core
// Overview of operation
// - 6-bit gain code selects -12 to +48 db in 1 db steps.
// - alternative 3-bit code selects -12 to +36 db in 8 db steps.
// - two cascaded coarse stages cover -12 to +42 db in 6 db steps.
// - fine stage adds 0 to 6 db in 1 db steps.
// - a lookup table splits total gain into coarse and fine settings.
// - offset cancellation runs after reset and on serial request.
// - during offset cal, first stage input shorted and all stages high gain.
// - servo steps cal dac until offset within +/-32 lsb.
// - each target write starts filter cal, done within 100 us.
// - config bit 0 enables filter, default on, cleared means bypass.
// - target register holds 8-bit cutoff target.
// - rewriting the same target value recalibrates the filter.
`timescale 1ns/1ps
`default_nettype none
module rxg_ctrl #(
  parameter int OCAL_SETTLE = rxg_pkg::OCAL_SETTLE_CYC,
  parameter int FCAL_STEP = rxg_pkg::FCAL_STEP_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ser_clk,
  input wire logic ser_en_n,
  input wire logic ser_din,
  output logic ser_dout,
  input wire logic signed [rxg_pkg::ADC_W-1:0] adc_offset,
  input wire logic filt_cmp,
  output logic [2:0] coarse1_lvl,
  output logic [2:0] coarse2_lvl,
  output logic [2:0] fine_lvl,
  output logic input_short,
  output logic [rxg_pkg::CAL_DAC_W-1:0] cal_dac,
  output logic lpf_bypass,
  output logic [7:0] lpf_target,
  output logic [rxg_pkg::FCAL_BITS-1:0] lpf_cap_code
);
  import rxg_pkg::*;

  // ==========================================================================
  // pin synchronisers
  logic [2:0] sclk_ff;
  logic [1:0] sen_ff;
  logic [1:0] sdi_ff;
  logic [1:0] cmp_ff;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sclk_ff <= 3'h0;
      sen_ff <= 2'h3;
      sdi_ff <= 2'h0;
      cmp_ff <= 2'h0;
    end else begin
      sclk_ff <= {sclk_ff[1:0], ser_clk};
      sen_ff <= {sen_ff[0], ser_en_n};
      sdi_ff <= {sdi_ff[0], ser_din};
      cmp_ff <= {cmp_ff[0], filt_cmp};
    end
  end
  wire sclk_rise = sclk_ff[1] & ~sclk_ff[2];
  wire sclk_fall = ~sclk_ff[1] & sclk_ff[2];
  wire sel = ~sen_ff[1];

  // ==========================================================================
  // serial slave
  logic [4:0] bit_cnt_ff;
  logic [15:0] sh_in_ff;
  logic [7:0] sh_out_ff;
  logic [7:0] rd_data;
  logic [7:0] cfg_ff;
  logic [7:0] target_ff;
  logic [7:0] gain_ctl_ff;
  logic wr_target;
  logic ocal_req;
  logic ocal_busy;
  logic ocal_fail_ff;
  logic fcal_busy;
  wire [15:0] shifted = {sh_in_ff[14:0], sdi_ff[1]};
  wire frame_done = sel & sclk_rise & (bit_cnt_ff == 5'(SER_FRAME_BITS - 1));
  wire wr_strobe = frame_done & ~sh_in_ff[14];
  wire [6:0] wr_addr = sh_in_ff[13:7];

  always_comb begin
    unique case (shifted[6:0])
      ADDR_RX_PATH_CONFIG: rd_data = cfg_ff;
      ADDR_FILTER_CUTOFF_TARGET: rd_data = target_ff;
      ADDR_GAIN_CONTROL: rd_data = gain_ctl_ff;
      ADDR_CAL_STATUS: rd_data = {5'h00, ocal_fail_ff, fcal_busy, ocal_busy};
      ADDR_CAL_DAC: rd_data = cal_dac;
      default: rd_data = 8'h00;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      bit_cnt_ff <= 5'h00;
      sh_in_ff <= 16'h0000;
    end else if (!sel) begin
      bit_cnt_ff <= 5'h00; // deselect aborts a partial frame
    end else if (sclk_rise) begin
      bit_cnt_ff <= frame_done ? 5'h00 : 5'(bit_cnt_ff + 5'h01);
      sh_in_ff <= shifted;
    end
  end

  // read data loads after the header and shifts out on falling edges
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sh_out_ff <= 8'h00;
      ser_dout <= 1'b0;
    end else if (sel & sclk_rise & (bit_cnt_ff == 5'(SER_HDR_BITS - 1)) & shifted[7]) begin
      sh_out_ff <= rd_data;
    end else if (sel & sclk_fall & (bit_cnt_ff >= 5'(SER_HDR_BITS))) begin
      ser_dout <= sh_out_ff[7];
      sh_out_ff <= {sh_out_ff[6:0], 1'b0};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= RST_RX_PATH_CONFIG;
      target_ff <= RST_FILTER_CUTOFF_TARGET;
      gain_ctl_ff <= RST_GAIN_CONTROL;
    end else if (wr_strobe) begin
      if (wr_addr == ADDR_RX_PATH_CONFIG) cfg_ff <= shifted[7:0];
      if (wr_addr == ADDR_FILTER_CUTOFF_TARGET) target_ff <= shifted[7:0];
      if (wr_addr == ADDR_GAIN_CONTROL) gain_ctl_ff <= shifted[7:0];
    end
  end
  // any write counts, even of an unchanged value
  assign wr_target = wr_strobe & (wr_addr == ADDR_FILTER_CUTOFF_TARGET);
  assign ocal_req = wr_strobe & (wr_addr == ADDR_CAL_CONTROL) & shifted[CALCTL_OCAL_REQ_BIT];

  // ==========================================================================
  // gain lookup
  rxg_gain_if gif ();
  assign gif.gain_code = gain_ctl_ff[GAIN_CODE_W-1:0];
  assign gif.alt_mode = gain_ctl_ff[GAIN_ALT_BIT];
  rxg_gain_lut u_lut (
    .clk(clk),
    .rst_n(rst_n),
    .gif(gif)
  );

  // ==========================================================================
  // offset calibration
  typedef enum logic [2:0] {
    OC_IDLE = 3'b000,
    OC_SETTLE = 3'b001,
    OC_CHECK = 3'b010,
    OC_RESTORE = 3'b011,
    OC_RELEASE = 3'b100
  } rxg_ocal_t;
  rxg_ocal_t oc_st_ff;
  logic [15:0] oc_cnt_ff;
  logic [7:0] oc_steps_ff;
  logic boot_ff;
  assign ocal_busy = (oc_st_ff != OC_IDLE);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      oc_st_ff <= OC_IDLE;
      oc_cnt_ff <= 16'h0000;
      oc_steps_ff <= 8'h00;
      boot_ff <= 1'b1;
      cal_dac <= CAL_DAC_MID;
      ocal_fail_ff <= 1'b0;
    end else begin
      unique case (oc_st_ff)
        OC_IDLE: begin
          if (boot_ff | ocal_req) begin
            boot_ff <= 1'b0;
            oc_st_ff <= OC_SETTLE;
            oc_cnt_ff <= 16'h0000;
            oc_steps_ff <= 8'h00;
            ocal_fail_ff <= 1'b0;
          end
        end
        OC_SETTLE: begin
          oc_cnt_ff <= 16'(oc_cnt_ff + 16'h0001);
          if (oc_cnt_ff == 16'(OCAL_SETTLE - 1)) oc_st_ff <= OC_CHECK;
        end
        OC_CHECK: begin
          oc_cnt_ff <= 16'h0000;
          if ((adc_offset <= OFFSET_WINDOW_LSB) && (adc_offset >= -OFFSET_WINDOW_LSB)) begin
            oc_st_ff <= OC_RESTORE;
          end else if (oc_steps_ff == 8'(OCAL_MAX_STEPS)) begin
            ocal_fail_ff <= 1'b1; // servo ran out of range, keeps last code
            oc_st_ff <= OC_RESTORE;
          end else begin
            cal_dac <= adc_offset[ADC_W-1] ? 8'(cal_dac + 8'h01) : 8'(cal_dac - 8'h01);
            oc_steps_ff <= 8'(oc_steps_ff + 8'h01);
            oc_st_ff <= OC_SETTLE;
          end
        end
        OC_RESTORE: oc_st_ff <= OC_RELEASE;
        OC_RELEASE: oc_st_ff <= OC_IDLE;
        default: oc_st_ff <= OC_IDLE;
      endcase
    end
  end

  // gains come back one cycle before the short lifts, avoiding a spike
  wire force_high = (oc_st_ff == OC_SETTLE) | (oc_st_ff == OC_CHECK);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      coarse1_lvl <= 3'h0;
      coarse2_lvl <= 3'h0;
      fine_lvl <= 3'h0;
      input_short <= 1'b0;
    end else begin
      coarse1_lvl <= force_high ? STAGE1_MAX_LVL : gif.stage1_lvl;
      coarse2_lvl <= force_high ? STAGE2_MAX_LVL : gif.stage2_lvl;
      fine_lvl <= force_high ? FINE_MAX_LVL : gif.fine_lvl;
      input_short <= force_high | (oc_st_ff == OC_RESTORE);
    end
  end

  // ==========================================================================
  // filter calibration, successive approximation of the capacitor code
  logic [15:0] fc_cnt_ff;
  logic [3:0] fc_bit_ff;
  logic fc_busy_ff;
  assign fcal_busy = fc_busy_ff;
  wire [3:0] fc_hi = 4'(FCAL_BITS - 1);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      fc_busy_ff <= 1'b0;
      fc_cnt_ff <= 16'h0000;
      fc_bit_ff <= 4'h0;
      lpf_cap_code <= 8'h80;
      lpf_target <= RST_FILTER_CUTOFF_TARGET;
    end else if (wr_target) begin
      fc_busy_ff <= 1'b1;
      fc_cnt_ff <= 16'h0000;
      fc_bit_ff <= fc_hi;
      lpf_cap_code <= 8'h80;
      lpf_target <= shifted[7:0];
    end else if (fc_busy_ff) begin
      fc_cnt_ff <= 16'(fc_cnt_ff + 16'h0001);
      if (fc_cnt_ff == 16'(FCAL_STEP - 1)) begin
        // eight settle steps fit under the time limit with a step to spare
        fc_cnt_ff <= 16'h0000;
        if (!cmp_ff[1]) lpf_cap_code[fc_bit_ff[2:0]] <= 1'b0;
        if (fc_bit_ff == 4'h0) begin
          fc_busy_ff <= 1'b0;
        end else begin
          lpf_cap_code[fc_bit_ff[2:0] - 3'h1] <= 1'b1;
          fc_bit_ff <= 4'(fc_bit_ff - 4'h1);
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lpf_bypass <= 1'b0;
    end else begin
      lpf_bypass <= ~cfg_ff[CFG_LPF_EN_BIT];
    end
  end
endmodule // rxg_ctrl
`default_nettype wire

/* test/rxg_ctrl_chk.sv */
// port assertions for the receive gain and calibration control
`timescale 1ns/1ps
`default_nettype none
module rxg_ctrl_chk #(
  parameter int OCAL_SETTLE = 4
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic signed [11:0] adc_offset,
  input wire logic [2:0] coarse1_lvl,
  input wire logic [2:0] coarse2_lvl,
  input wire logic [2:0] fine_lvl,
  input wire logic input_short,
  input wire logic [7:0] cal_dac,
  input wire logic [7:0] lpf_target,
  input wire logic [7:0] lpf_cap_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  logic hi_gain;
  int short_ff;
  assign hi_gain = coarse1_lvl == 3'h5 && coarse2_lvl == 3'h4 && fine_lvl == 3'h6;
  // ==========================================
  // servo length bound: 255 steps of settle plus check
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      short_ff <= 0;
    end else begin
      short_ff <= input_short ? short_ff + 1 : 0;
    end
  end
  // ==========================================
  // assertions
  a_coarse_range: assert property (coarse1_lvl <= 3'h5 && coarse2_lvl <= 3'h4)
    else $error("coarse level out of range");
  a_fine_range: assert property (fine_lvl <= 3'h6)
    else $error("fine level out of range");
  a_stage_cascade: assert property (coarse2_lvl != 3'h0 |-> coarse1_lvl == 3'h5)
    else $error("second stage used before first is full");
  a_cal_forced: assert property ($rose(input_short) |-> hi_gain)
    else $error("short without forced gains");
  a_restore_first: assert property ($fell(input_short) |-> !hi_gain && !$past(hi_gain))
    else $error("short released before gains restored");
  a_dac_quiet: assert property ($changed(cal_dac) |-> $past(input_short))
    else $error("cal dac moved outside offset cal");
  a_dac_sense: assert property ($changed(cal_dac) |->
    cal_dac == (($past(adc_offset) < 0) ? $past(cal_dac) + 8'h01 : $past(cal_dac) - 8'h01))
    else $error("cal dac step wrong");
  a_sar_restart: assert property ($changed(lpf_target) |-> lpf_cap_code == 8'h80)
    else $error("filter search not restarted");
  a_cal_bounded: assert property (short_ff < 255 * (OCAL_SETTLE + 2) + 8)
    else $error("offset cal too long");
endmodule // rxg_ctrl_chk
`default_nettype wire

/* test/rxg_analog_model.sv */
// analog receive chain stand-in: offset plant and filter comparator
`timescale 1ns/1ps
`default_nettype none
module rxg_analog_model (
  input wire logic input_short,
  input wire logic [7:0] cal_dac,
  input wire logic [7:0] lpf_target,
  input wire logic [7:0] lpf_cap_code,
  output logic signed [11:0] adc_offset,
  output logic filt_cmp
);
  // null at dac 0x90, 8 lsb per step; unshorted input shows full signal
  assign adc_offset = input_short ? ({4'h0, cal_dac} - 12'h090) << 3 : 12'sh7ff;
  // ideal cap code is the inverted target, so a stale target is visible
  assign filt_cmp = lpf_cap_code <= ~lpf_target;
endmodule // rxg_analog_model
`default_nettype wire

/* test/tb.sv */
// self-checking bench for the receive gain and calibration control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk = 0, rst_n = 0, ser_clk = 0, ser_en_n = 1, ser_din = 0;
  wire logic signed [11:0] adc_offset;
  wire logic filt_cmp, ser_dout, input_short, lpf_bypass;
  wire logic [2:0] c1, c2, fl;
  wire logic [7:0] cal_dac, lpf_target, cap;
  int failures = 0, num_checks = 0, rises = 0;
  logic [7:0] rd;
  always #12.5 clk = ~clk;
  always @(posedge input_short) rises++;
  rxg_ctrl #(.OCAL_SETTLE(4), .FCAL_STEP(40)) i_dut (.clk(clk), .rst_n(rst_n), .ser_clk(ser_clk),
    .ser_en_n(ser_en_n), .ser_din(ser_din), .ser_dout(ser_dout), .adc_offset(adc_offset),
    .filt_cmp(filt_cmp), .coarse1_lvl(c1), .coarse2_lvl(c2), .fine_lvl(fl), .input_short(input_short),
    .cal_dac(cal_dac), .lpf_bypass(lpf_bypass), .lpf_target(lpf_target), .lpf_cap_code(cap));
  rxg_analog_model i_ana (.input_short(input_short), .cal_dac(cal_dac), .lpf_target(lpf_target),
    .lpf_cap_code(cap), .adc_offset(adc_offset), .filt_cmp(filt_cmp));
  // ==========================================
  // helpers
  function automatic logic [8:0] gexp(input logic [6:0] g);
    logic [5:0] i;
    logic [3:0] c;
    logic [2:0] s;
    i = g[6] ? ((g[2:0] > 3'h6) ? 6'h30 : {g[2:0], 3'h0}) : (g[5:0] > 6'h3c ? 6'h3c : g[5:0]);
    c = (i / 6 > 9) ? 4'h9 : 4'(i / 6);
    s = c > 5 ? 3'h5 : c[2:0];
    return {s, 3'(c - 4'(s)), 3'(i - 6 * c)};
  endfunction
  task automatic chk(input string n, input logic [11:0] e, input logic [11:0] g);
    num_checks++;
    if (g !== e) begin
      failures++;
      $display("BAD %s exp %h got %h", n, e, g);
    end
  endtask
  // w=1 write; read data lands in rd
  task automatic xfer(input logic w, input logic [6:0] a, input logic [7:0] d);
    logic [15:0] f;
    f = {~w, a, d};
    ser_en_n = 1'b0;
    for (int i = 15; i >= 0; i--) begin
      ser_din = f[i];
      repeat (6) @(negedge clk);
      if (i < 8) rd[i] = ser_dout;
      ser_clk = 1'b1;
      repeat (6) @(negedge clk);
      ser_clk = 1'b0;
    end
    repeat (6) @(negedge clk);
    ser_en_n = 1'b1;
    repeat (4) @(negedge clk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_power_up();
    repeat (3) @(negedge clk);
    chk("short", 12'h1, input_short);
    chk("forced", 12'h166, {c1, c2, fl});
    for (int k = 0; k < 4000 && input_short; k++) @(negedge clk);
    chk("short end", 12'h0, input_short);
    chk("dac", 12'h08c, cal_dac);
    chk("restored", gexp(7'h0c), {c1, c2, fl});
  endtask
  task automatic t_regs();
    xfer(0, 7'h07, 8'h00);
    chk("cfg", 12'h01, rd);
    chk("byp", 12'h0, lpf_bypass);
    xfer(1, 7'h07, 8'h00);
    chk("byp", 12'h1, lpf_bypass);
    xfer(0, 7'h08, 8'h00);
    chk("target", 12'h80, rd);
    xfer(0, 7'h20, 8'h00);
    chk("unmapped", 12'h00, rd);
    xfer(1, 7'h07, 8'h01);
    chk("byp", 12'h0, lpf_bypass);
  endtask
  task automatic t_gain();
    logic [6:0] codes [10] = '{7'h00, 7'h05, 7'h06, 7'h23, 7'h29, 7'h2a, 7'h30, 7'h3b, 7'h3c, 7'h3f};
    foreach (codes[n]) begin
      xfer(1, 7'h09, {1'b0, codes[n]});
      chk("gain", gexp(codes[n]), {c1, c2, fl});
    end
    // every alternate code, 8 db apart, top code held at +36 db
    for (int k = 0; k < 8; k++) begin
      xfer(1, 7'h09, 8'(8'h40 + k));
      chk("alt", gexp(7'(7'h40 + k)), {c1, c2, fl});
    end
  endtask
  task automatic t_filter();
    xfer(1, 7'h08, 8'h40);
    xfer(1, 7'h08, 8'h21);
    chk("tgt", 12'h21, lpf_target);
    repeat (340) @(negedge clk);
    chk("cap", 12'h0de, cap);
    xfer(1, 7'h08, 8'h21);
    chk("cap", 12'h080, cap);
    xfer(0, 7'h0b, 8'h00);
    chk("fbusy", 12'h1, rd[1]);
    repeat (340) @(negedge clk);
    chk("cap", 12'h0de, cap);
  endtask
  task automatic t_ocal_req();
    int n;
    n = rises;
    xfer(1, 7'h0a, 8'h01);
    repeat (40) @(negedge clk);
    chk("ocal runs", 12'(n + 1), 12'(rises));
    chk("dac", 12'h08c, cal_dac);
    chk("restored", gexp(7'h47), {c1, c2, fl});
    xfer(0, 7'h0b, 8'h00);
    chk("status", 12'h00, rd);
    xfer(0, 7'h0c, 8'h00);
    chk("dac rd", 12'h08c, rd);
    xfer(0, 7'h09, 8'h00);
    chk("gain rd", 12'h47, rd);
  endtask
  // mid-run reset must bring back defaults and rerun the boot offset cal
  task automatic t_reset();
    int n;
    n = rises;
    rst_n = 1'b0;
    repeat (2) @(negedge clk);
    chk("rst dac", 12'h080, cal_dac);
    chk("rst tgt", 12'h080, lpf_target);
    rst_n = 1'b1;
    repeat (3) @(negedge clk);
    chk("boot short", 12'h1, input_short);
    for (int k = 0; k < 4000 && input_short; k++) @(negedge clk);
    chk("boot runs", 12'(n + 1), 12'(rises));
    chk("boot dac", 12'h08c, cal_dac);
    chk("boot gain", gexp(7'h0c), {c1, c2, fl});
  endtask
  task automatic summarize();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    t_power_up();
    t_regs();
    t_gain();
    t_filter();
    t_ocal_req();
    t_reset();
    summarize();
  end
  // about 7100 cycles expected; cut off at 40000
  initial begin
    #1000000;
    failures++;
    summarize();
  end
endmodule // tb
bind rxg_ctrl rxg_ctrl_chk #(.OCAL_SETTLE(OCAL_SETTLE)) i_chk (.clk(clk), .rst_n(rst_n),
  .adc_offset(adc_offset), .coarse1_lvl(coarse1_lvl), .coarse2_lvl(coarse2_lvl), .fine_lvl(fine_lvl),
  .input_short(input_short), .cal_dac(cal_dac), .lpf_target(lpf_target), .lpf_cap_code(lpf_cap_code));
`default_nettype wire
